// ---- src/aot_pkg.sv ----
package aot_pkg;
  // System clock rate and derived cycle counts
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned STANDBY_WAKE_NS = 15000;
  localparam int unsigned STANDBY_WAKE_CYC = (STANDBY_WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned POWER_DOWN_PIN_WAKE_US = 5000;
  localparam int unsigned POWER_DOWN_PIN_WAKE_CYC = POWER_DOWN_PIN_WAKE_US * CLK_MHZ;
  // Register reset length in sample periods (130 us at 65 Msps)
  localparam int unsigned REGRST_US = 130;
  localparam int unsigned REF_MSPS = 65;
  localparam int unsigned REGRST_SAMPLES = REGRST_US * REF_MSPS;

  // One sample period is sixteen system clocks, so one delay step is one clock
  localparam logic [3:0] DATA_BASE_PH = 4'h8;
  localparam logic [3:0] CLK_LEAD = 4'h2;
  localparam logic [3:0] HALF_PERIOD = 4'h8;
  localparam int unsigned PIPE_LAT = 9;

  // Serial register map
  localparam logic [6:0] ADDR_PM = 7'h00;
  localparam logic [6:0] ADDR_FMT = 7'h01;
  localparam logic [6:0] ADDR_TIMING = 7'h02;
  localparam logic [6:0] ADDR_SWRST = 7'h0A;
  localparam logic [6:0] ADDR_STATUS = 7'h0B;
  localparam logic [7:0] SWRST_KEY = 8'h5A;
  localparam logic [7:0] PM_RESET = 8'hA0;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h80;

  // Field positions
  localparam int unsigned FMT_CODE_LSB = 0;
  localparam int unsigned FMT_REV_BIT = 2;
  localparam int unsigned FMT_MUX_BIT = 3;
  localparam int unsigned TM_DDLY_LSB = 0;
  localparam int unsigned TM_CDLY_LSB = 3;
  localparam int unsigned TM_HALF_BIT = 6;
  localparam int unsigned TM_SKIP_BIT = 7;
  localparam int unsigned PM_PIN_HI_LSB = 4;

  // Power modes per channel and output codings
  typedef logic [1:0] pm_mode_type;
  localparam pm_mode_type PM_NORMAL = 2'h0;
  localparam pm_mode_type PM_STANDBY = 2'h1;
  localparam pm_mode_type PM_SHUTDOWN = 2'h2;
  localparam logic [1:0] CODE_OFFSET = 2'h1;
  localparam logic [1:0] CODE_GRAY = 2'h2;

  // Serial frame: R/W, 7-bit address, 8-bit data, MSB first
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned SCLK_HALF = 8;
  localparam logic [8:0] SYNC_IDLE = 9'h080;

  // Controller Avalon-MM byte offsets
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_STAT = 4'h4;
  localparam logic [3:0] AV_PINS = 4'h8;
  localparam logic [3:0] AV_CAP = 4'hC;
  localparam logic [4:0] PINS_RESET = 5'h00;

  // Delay code to clock steps, modulo one sample period
  function automatic logic [3:0] dly_steps(input logic [2:0] code);
    dly_steps = code[2] ? 4'(5'h10 - {3'h0, code[1:0]}) : {2'h0, code[1:0]};
  endfunction : dly_steps

  // Delay code to ordered rank, 0 is -3 steps, 6 is +3 steps
  function automatic logic [2:0] dly_rank(input logic [2:0] code);
    dly_rank = code[2] ? 3'(3'h3 - {1'h0, code[1:0]}) : 3'(3'h3 + {1'h0, code[1:0]});
  endfunction : dly_rank
endpackage : aot_pkg

// ---- src/aot_link_if.sv ----
interface aot_link_if;
  logic sclk;
  logic csn;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic sdio;
  logic power_down_pin;
  logic serial_port_disable;
  logic bus_arrangement_pin;
  logic [1:0] coding_pins;
  logic output_clock;
  logic [7:0] data_a;
  logic [7:0] data_b;

  // Shared data wire, pulled high when nobody drives it
  assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);

  modport dev (
    input sclk, csn, sdio, power_down_pin, serial_port_disable,
    input bus_arrangement_pin, coding_pins,
    output sdio_dev_o, sdio_dev_oe, output_clock, data_a, data_b
  );
  modport host (
    output sclk, csn, sdio_host_o, sdio_host_oe, power_down_pin,
    output serial_port_disable, bus_arrangement_pin, coding_pins,
    input sdio, output_clock, data_a, data_b
  );
endinterface : aot_link_if

// ---- src/aot_dev.sv ----
// How it works
// - Reset: aligner skipped, no half, codes 000
// - Parallel mode: coding pins pick output format
// - Parallel mode: pin picks muxed or dual bus
// - Bit reversal puts LSB on top pin
// - Host keeps clock delay not above data when the aligner is skipped
// - Host uses recommended delay codes per rate; here the delay codes are whatever AV_CMD writes send
// - Default timing at full rate adds one period
// - Power pin selects between two register states
// - Default: pin high shuts down, low runs
// - Each channel power managed by register
// - Standby wakes in 15 us, clock kept
// - Shutdown wakes in 5 ms
// - Defaults load once supply and clock present
// - Registers kept while analog supply stays
// - Writing 5Ah to 0Ah resets registers
// - Pin falling while port disabled resets registers
// - Register reset lasts 8450 sample periods
// - Delay codes step one sixteenth period
// - Half-period delay, none in muxed mode
// - Words appear after nine sample periods
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
module aot_dev #(
  parameter int unsigned POWER_DOWN_PIN_WAKE = aot_pkg::POWER_DOWN_PIN_WAKE_CYC,
  parameter int unsigned RST_LEN = aot_pkg::REGRST_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic analog_supply,
  input wire logic full_rate,
  input wire logic [7:0] sample_a,
  input wire logic [7:0] sample_b,
  aot_link_if.dev link,
  output logic sample_take,
  output logic reg_reset_busy,
  output aot_pkg::pm_mode_type pwr_state_a,
  output aot_pkg::pm_mode_type pwr_state_b
);
  import aot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [8:0] meta_ff;
  logic [8:0] sync_ff;
  logic sclk_q_ff;
  logic pd_q_ff;

  // Every link pin and the supply input pass two flops before use; samples and full_rate are used unsynchronised
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= SYNC_IDLE;
      sync_ff <= SYNC_IDLE;
      sclk_q_ff <= 1'b0;
      pd_q_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= {link.sclk, link.csn, link.sdio, link.power_down_pin,
                  link.serial_port_disable, link.bus_arrangement_pin,
                  link.coding_pins, analog_supply};
      sync_ff <= meta_ff;
      sclk_q_ff <= sync_ff[8];
      pd_q_ff <= sync_ff[5];
    end
  end

  logic s_sclk, s_csn, s_sdio, s_pd, s_spd, s_bus, s_sup;
  logic [1:0] s_code;
  assign {s_sclk, s_csn, s_sdio, s_pd, s_spd, s_bus, s_code, s_sup} = sync_ff;
  logic sclk_rise, sclk_fall, pd_fall;
  assign sclk_rise = s_sclk & ~sclk_q_ff & ~s_csn & ~s_spd;
  assign sclk_fall = ~s_sclk & sclk_q_ff & ~s_csn & ~s_spd;
  assign pd_fall = ~s_pd & pd_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  logic [4:0] bit_cnt_ff;
  logic [14:0] rx_ff;
  logic [7:0] tx_ff;
  logic sdio_o_ff;
  logic sdio_oe_ff;
  logic [15:0] frame;
  logic wr_go;
  logic [7:0] pm_ff, fmt_ff, tm_ff;
  logic busy_ff;
  logic [7:0] rd_val;

  assign frame = {rx_ff, s_sdio};
  assign wr_go = sclk_rise & (bit_cnt_ff == 5'(FRAME_BITS - 1)) & ~frame[15] & ~busy_ff;

  // Readback mux, unmapped addresses read zero
  always_comb begin
    case (rx_ff[6:0])
      ADDR_PM: rd_val = pm_ff;
      ADDR_FMT: rd_val = fmt_ff;
      ADDR_TIMING: rd_val = tm_ff;
      ADDR_STATUS: rd_val = {7'h00, busy_ff};
      default: rd_val = 8'h00;
    endcase
  end

  // Shift in on rising edges, drive read data after falling edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_cnt_ff <= 5'h00;
      rx_ff <= 15'h0000;
      tx_ff <= 8'h00;
      sdio_o_ff <= 1'b0;
      sdio_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (s_csn || s_spd) begin
        bit_cnt_ff <= 5'h00;
        sdio_oe_ff <= 1'b0;
      end else if (sclk_rise) begin
        rx_ff <= frame[14:0];
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end else if (sclk_fall && bit_cnt_ff == 5'h08 && rx_ff[7]) begin
        // Read frame: address complete, take the turn on the wire
        tx_ff <= {rd_val[6:0], 1'b0};
        sdio_o_ff <= rd_val[7];
        sdio_oe_ff <= 1'b1;
      end else if (sclk_fall && bit_cnt_ff > 5'h08 && sdio_oe_ff) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
        sdio_o_ff <= tx_ff[7];
        sdio_oe_ff <= (bit_cnt_ff != 5'(FRAME_BITS));
      end
    end
  end
  assign link.sdio_dev_o = sdio_o_ff;
  assign link.sdio_dev_oe = sdio_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register reset sequencer and registers
  logic loaded_ff;
  logic [17:0] rcnt_ff;
  logic [3:0] phase_ff;
  logic tick;
  logic rst_start;

  assign tick = (phase_ff == 4'hF);
  assign rst_start = s_sup & (~loaded_ff
                    | (wr_go & frame[14:8] == ADDR_SWRST & frame[7:0] == SWRST_KEY)
                    | (s_spd & pd_fall));

  // sixteen clocks per sample period, counted from the start edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loaded_ff <= 1'b0;
      busy_ff <= 1'b0;
      rcnt_ff <= 18'h00000;
    end else if (clk_en) begin
      if (!s_sup) begin
        loaded_ff <= 1'b0;
        busy_ff <= 1'b0;
      end else if (rst_start) begin
        loaded_ff <= 1'b1;
        busy_ff <= 1'b1;
        rcnt_ff <= 18'h00000;
      end else if (busy_ff) begin
        // Exact length, no dependence on the phase at start
        busy_ff <= (rcnt_ff != 18'(RST_LEN * 16 - 1));
        rcnt_ff <= rcnt_ff + 18'h00001;
      end
    end
  end
  assign reg_reset_busy = busy_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pm_ff <= PM_RESET;
      fmt_ff <= FMT_RESET;
      tm_ff <= TIMING_RESET;
    end else if (clk_en) begin
      if (busy_ff || rst_start || !s_sup) begin
        pm_ff <= PM_RESET;
        fmt_ff <= FMT_RESET;
        tm_ff <= TIMING_RESET;
      end else if (wr_go) begin
        case (frame[14:8])
          ADDR_PM: pm_ff <= frame[7:0];
          ADDR_FMT: fmt_ff <= frame[7:0];
          ADDR_TIMING: tm_ff <= frame[7:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel power state and wake timers
  pm_mode_type st_ff [2];
  logic [16:0] wake_ff [2];
  logic rdy [2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_pwr
    pm_mode_type mode;
    // pin level picks the register field
    // default field values shut down on high
    assign mode = s_pd ? pm_ff[PM_PIN_HI_LSB + 2 * ch +: 2] : pm_ff[2 * ch +: 2];
    assign rdy[ch] = (st_ff[ch] == PM_NORMAL) && (wake_ff[ch] == 17'h00000);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        st_ff[ch] <= PM_NORMAL;
        wake_ff[ch] <= 17'h00000;
      end else if (clk_en) begin
        st_ff[ch] <= mode;
        if (mode == PM_NORMAL && st_ff[ch] == PM_STANDBY) begin
          wake_ff[ch] <= 17'(STANDBY_WAKE_CYC);
        end else if (mode == PM_NORMAL && st_ff[ch] != PM_NORMAL) begin
          wake_ff[ch] <= 17'(POWER_DOWN_PIN_WAKE);
        end else if (wake_ff[ch] != 17'h00000) begin
          wake_ff[ch] <= wake_ff[ch] - 17'h00001;
        end
      end
    end
  end
  assign pwr_state_a = st_ff[0];
  assign pwr_state_b = st_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sample pipeline
  logic [15:0] pipe_ff [PIPE_LAT + 1];
  logic take_ff;
  logic [7:0] tm_act_ff;

  // Phase of the sixteen-step sample period
  // Timing taken at the period end so edges never shift mid-period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_ff <= 4'h0;
      take_ff <= 1'b0;
      tm_act_ff <= TIMING_RESET;
    end else if (clk_en) begin
      phase_ff <= phase_ff + 4'h1;
      take_ff <= tick;
      if (tick) begin
        tm_act_ff <= tm_ff;
      end
    end
  end
  assign sample_take = take_ff;

  // ten-stage latency line, idle channels give zero
  for (genvar k = 0; k <= PIPE_LAT; k++) begin : g_pipe
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        pipe_ff[k] <= 16'h0000;
      end else if (clk_en && tick) begin
        if (k == 0) begin
          pipe_ff[k] <= {rdy[1] ? sample_b : 8'h00, rdy[0] ? sample_a : 8'h00};
        end else begin
          pipe_ff[k] <= pipe_ff[k - 1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output formatting and timing
  logic [1:0] code;
  logic mux;
  logic rev;
  logic [15:0] word;
  logic [3:0] skew, dph, cph;

  assign code = s_spd ? s_code : fmt_ff[FMT_CODE_LSB +: 2];
  assign mux = s_spd ? s_bus : fmt_ff[FMT_MUX_BIT];
  assign rev = ~s_spd & fmt_ff[FMT_REV_BIT];
  // one more period with default timing at full rate
  assign word = (full_rate && tm_ff == TIMING_RESET) ? pipe_ff[PIPE_LAT] : pipe_ff[PIPE_LAT - 1];

  // Aligner active shifts both edges one step earlier
  assign skew = tm_act_ff[TM_SKIP_BIT] ? 4'h0 : 4'hF;
  // half period only on the dual bus
  assign dph = DATA_BASE_PH + dly_steps(tm_act_ff[TM_DDLY_LSB +: 3]) + skew
             + ((tm_act_ff[TM_HALF_BIT] && !mux) ? HALF_PERIOD : 4'h0);
  assign cph = DATA_BASE_PH - CLK_LEAD + dly_steps(tm_act_ff[TM_CDLY_LSB +: 3]) + skew;

  // Raw samples are offset binary
  function automatic logic [7:0] fmt(input logic [7:0] raw, input logic [1:0] c,
                                     input logic r);
    logic [7:0] v;
    v = (c == CODE_OFFSET) ? raw : (c == CODE_GRAY) ? (raw ^ (raw >> 1)) : (raw ^ 8'h80);
    fmt = r ? {<<{v}} : v;
  endfunction : fmt

  logic [7:0] da_ff, db_ff;
  logic oclk_ff;
  // Data changes at the data phase, output clock rises at its own phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      da_ff <= 8'h00;
      db_ff <= 8'h00;
      oclk_ff <= 1'b0;
    end else if (clk_en) begin
      if (phase_ff == dph) begin
        da_ff <= fmt(word[7:0], code, rev);
        db_ff <= mux ? 8'h00 : fmt(word[15:8], code, rev);
      end else if (mux && phase_ff == dph + HALF_PERIOD) begin
        da_ff <= fmt(word[15:8], code, rev);
      end
      if (phase_ff == cph) begin
        oclk_ff <= 1'b1;
      end else if (phase_ff == cph + HALF_PERIOD) begin
        oclk_ff <= 1'b0;
      end
    end
  end
  assign link.data_a = da_ff;
  assign link.data_b = db_ff;
  assign link.output_clock = oclk_ff;
endmodule : aot_dev

// ---- src/aot_host.sv ----
module aot_host (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  aot_link_if.host link,
  output logic cap_valid,
  output logic [7:0] cap_a,
  output logic [7:0] cap_b
);
  import aot_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SHIFT = 3'b010,
    H_END = 3'b100
  } hst_state_type;

  hst_state_type st_ff;
  logic [15:0] frame_ff;
  logic [3:0] idx_ff;
  logic [3:0] div_ff;
  logic sclk_ff, csn_ff, so_ff, soe_ff;
  logic [7:0] rd_ff;
  logic err_ff;
  logic [4:0] pins_ff;
  logic wait_ff;
  logic [31:0] rdat_ff;
  logic [15:0] cnt_ff;
  logic [17:0] meta_ff, sync_ff;
  logic oclk_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, command writes stall while a frame runs
  logic stall, accept, bad_timing;
  assign stall = avs_write & (avs_address == AV_CMD) & (st_ff != H_IDLE);
  assign accept = (avs_read | avs_write) & ~wait_ff;
  // clock delay above data delay refused when the aligner skip bit is set
  assign bad_timing = ~avs_writedata[15] & (avs_writedata[14:8] == ADDR_TIMING)
                    & avs_writedata[TM_SKIP_BIT]
                    & (dly_rank(avs_writedata[TM_CDLY_LSB +: 3])
                       > dly_rank(avs_writedata[TM_DDLY_LSB +: 3]));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdat_ff <= 32'h00000000;
      pins_ff <= PINS_RESET;
      err_ff <= 1'b0;
    end else if (clk_en) begin
      wait_ff <= ~((avs_read | avs_write) & wait_ff & ~stall);
      if ((avs_read || avs_write) && wait_ff && !stall) begin
        case (avs_address)
          AV_STAT: rdat_ff <= {22'h000000, err_ff, st_ff != H_IDLE, rd_ff};
          AV_PINS: rdat_ff <= {27'h0000000, pins_ff};
          AV_CAP: rdat_ff <= {cnt_ff, cap_b, cap_a};
          default: rdat_ff <= 32'h00000000;
        endcase
      end
      if (accept && avs_write && avs_address == AV_PINS) begin
        pins_ff <= avs_writedata[4:0];
      end
      if (accept && avs_write && avs_address == AV_CMD) begin
        err_ff <= bad_timing;
      end
    end
  end
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdat_ff;

  // pins are levels only, the sample clock is never gated here
  assign {link.bus_arrangement_pin, link.coding_pins} = pins_ff[4:2];
  assign link.serial_port_disable = pins_ff[1];
  // host may pulse the pin low with the serial port disabled to reset registers
  assign link.power_down_pin = pins_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // Serial master: clock made here by a divider
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= H_IDLE;
      frame_ff <= 16'h0000;
      idx_ff <= 4'h0;
      div_ff <= 4'h0;
      sclk_ff <= 1'b0;
      csn_ff <= 1'b1;
      so_ff <= 1'b0;
      soe_ff <= 1'b0;
      rd_ff <= 8'h00;
    end else if (clk_en) begin
      div_ff <= (div_ff == 4'(SCLK_HALF - 1)) ? 4'h0 : div_ff + 4'h1;
      case (st_ff)
        H_IDLE: begin
          div_ff <= 4'h0;
          // reset key goes out as an ordinary write
          if (accept && avs_write && avs_address == AV_CMD && !bad_timing) begin
            frame_ff <= avs_writedata[15:0];
            idx_ff <= 4'hF;
            so_ff <= avs_writedata[15];
            soe_ff <= 1'b1;
            csn_ff <= 1'b0;
            st_ff <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (div_ff == 4'(SCLK_HALF - 1)) begin
            sclk_ff <= ~sclk_ff;
            if (!sclk_ff && idx_ff < 4'h8 && frame_ff[15]) begin
              rd_ff <= {rd_ff[6:0], sync_ff[17]};
            end
            if (sclk_ff && idx_ff == 4'h0) begin
              soe_ff <= 1'b0;
              st_ff <= H_END;
            end else if (sclk_ff) begin
              idx_ff <= idx_ff - 4'h1;
              so_ff <= frame_ff[idx_ff - 4'h1];
              soe_ff <= ~(frame_ff[15] && idx_ff <= 4'h8);
            end
          end
        end
        H_END: begin
          if (div_ff == 4'(SCLK_HALF - 1)) begin
            csn_ff <= 1'b1;
            st_ff <= H_IDLE;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_ff;
  assign link.csn = csn_ff;
  assign link.sdio_host_o = so_ff;
  assign link.sdio_host_oe = soe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sample capture on output clock edges
  logic [7:0] cap_a_ff, cap_b_ff;
  logic cv_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= 18'h00000;
      sync_ff <= 18'h00000;
      oclk_q_ff <= 1'b0;
      cap_a_ff <= 8'h00;
      cap_b_ff <= 8'h00;
      cv_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      meta_ff <= {link.sdio, link.output_clock, link.data_b, link.data_a};
      sync_ff <= meta_ff;
      oclk_q_ff <= sync_ff[16];
      cv_ff <= 1'b0;
      if (sync_ff[16] && !oclk_q_ff) begin
        // Rising edge: dual bus gives both, muxed bus gives channel B
        cap_b_ff <= pins_ff[4] ? sync_ff[7:0] : sync_ff[15:8];
        if (!pins_ff[4]) begin
          cap_a_ff <= sync_ff[7:0];
        end
        cv_ff <= 1'b1;
        cnt_ff <= cnt_ff + 16'h0001;
      end else if (!sync_ff[16] && oclk_q_ff && pins_ff[4]) begin
        cap_a_ff <= sync_ff[7:0];
      end
    end
  end
  assign cap_a = cap_a_ff;
  assign cap_b = cap_b_ff;
  assign cap_valid = cv_ff;
endmodule : aot_host

// ---- dv/aot_link_sva.sv ----
module aot_link_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csn,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic serial_port_disable,
  input wire logic output_clock,
  input wire logic [7:0] data_a
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [4:0] rises_ff;
  // Serial clock rises since the frame opened
  always_ff @(posedge clk_sys) begin
    if (rst || csn) begin
      rises_ff <= 5'h00;
    end else if ($rose(sclk)) begin
      rises_ff <= rises_ff + 5'h01;
    end
  end
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high time wrong");
  a_frame_bits: assert property ($rose(csn) |-> rises_ff == 5'h10)
    else $error("frame not sixteen bits");
  a_one_driver: assert property (!(sdio_dev_oe && sdio_host_oe))
    else $error("both ends drive data line");
  a_turn_late: assert property ($rose(sdio_dev_oe) |-> rises_ff == 5'h08)
    else $error("read data driven at wrong bit");
  a_idle_quiet: assert property (csn [*4] |-> !sdio_dev_oe)
    else $error("device drives while deselected");
  a_port_off: assert property (serial_port_disable |-> !sdio_dev_oe)
    else $error("disabled port drives data line");
  a_data_rise: assert property ($rose(output_clock) |-> $stable(data_a))
    else $error("data moves at output clock rise");
  a_data_fall: assert property ($fell(output_clock) |-> $stable(data_a))
    else $error("data moves at output clock fall");
  a_clk_high: assert property ($rose(output_clock) |-> output_clock [*8])
    else $error("output clock high time wrong");
  // Main traffic kinds seen
  cover property ($rose(csn) && rises_ff == 5'h10);
  cover property ($rose(sdio_dev_oe));
  cover property (serial_port_disable && $fell(output_clock));
endmodule : aot_link_chk

// ---- dv/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aot_pkg::*;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} aot_note_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest;
  logic reg_reset_busy;
  logic [7:0] sample_a = 8'h00;
  logic [7:0] sample_b = 8'h00;
  logic full_rate = 1'b0;
  pm_mode_type pwr_state_a;
  pm_mode_type pwr_state_b;
  logic [16:0] seed = 17'h14D85;
  int error_cnt = 0;
  int checks_done = 0;
  int busy_cnt = 0;
  aot_note_type notes[$];
  aot_link_if link ();
  // Reset reload kept short so a run stays brief
  aot_dev #(.POWER_DOWN_PIN_WAKE(20), .RST_LEN(40)) aot_dev_inst (.clk_sys(clk_sys), .rst(rst),
    .clk_en(1'b1), .analog_supply(1'b1), .full_rate(full_rate), .sample_a(sample_a),
    .sample_b(sample_b), .link(link), .sample_take(), .reg_reset_busy(reg_reset_busy),
    .pwr_state_a(pwr_state_a), .pwr_state_b(pwr_state_b));
  aot_host aot_host_inst (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link),
    .cap_valid(), .cap_a(), .cap_b());
  aot_link_chk aot_link_chk_inst (.clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .csn(link.csn),
    .sdio_host_oe(link.sdio_host_oe), .sdio_dev_oe(link.sdio_dev_oe),
    .serial_port_disable(link.serial_port_disable), .output_clock(link.output_clock),
    .data_a(link.data_a));
  ////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    lfsr = {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  // Expected output word for a coding and bit order
  function automatic logic [7:0] fmtx(input logic [7:0] v, input logic [1:0] c, input logic r);
    logic [7:0] t;
    t = (c == CODE_OFFSET) ? v : ((c == CODE_GRAY) ? (v ^ (v >> 1)) : (v ^ 8'h80));
    fmtx = r ? {<<{t}} : t;
  endfunction : fmtx
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g,
      input logic [31:0] m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("BAD %s exp=%h got=%h", nm, e & m, g & m);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      finish_test();
    end
  endtask : bound
  // Avalon cycle; starts on a fresh edge so strobes never change twice in one step
  task automatic av(input logic r, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= r;
    avs_write <= !r;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 2000);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    bound(n, 2000);
  endtask : av
  // Serial access, then poll until the frame is over
  task automatic sreg(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    av(1'b0, AV_CMD, {16'h0, !w, a, d});
    do begin
      av(1'b1, AV_STAT, 32'h0);
      n++;
    end while (rd[8] !== 1'b0 && n < 500);
    bound(n, 500);
  endtask : sreg
  task automatic rd_reg(input string nm, input logic [6:0] a, input logic [7:0] e);
    sreg(1'b0, a, 8'h00);
    notes.push_back('{nm, {24'h0, e}, 32'h0000_00FF});
    av(1'b1, AV_STAT, 32'h0);
  endtask : rd_reg
  task automatic dev_idle();
    int n;
    n = 0;
    do begin
      sreg(1'b0, ADDR_STATUS, 8'h00);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    bound(n, 50);
  endtask : dev_idle
  // Fresh random samples, new format, then compare the captured pair
  task automatic fmt_case(input logic [1:0] c, input logic r, input logic p, input logic x);
    seed = lfsr(seed);
    sample_a <= seed[7:0];
    sample_b <= seed[15:8];
    if (p) av(1'b0, AV_PINS, {27'h0, x, c, 2'h2});
    else sreg(1'b1, ADDR_FMT, {5'h0, r, c});
    repeat (400) @(posedge clk_sys);
    notes.push_back('{"capture", {16'h0, fmtx(seed[15:8], c, r), fmtx(seed[7:0], c, r)},
      32'h0000_FFFF});
    av(1'b1, AV_CAP, 32'h0);
  endtask : fmt_case
  ////////////////////////////////////////
  // Read answers taken at the accept edge against the oldest note
  always @(posedge clk_sys) begin : mon
    aot_note_type nt;
    if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      chk(nt.nm, nt.e, avs_readdata, nt.m);
    end
  end
  // Total register reset cycles since busy_cnt was last cleared
  always @(posedge clk_sys) begin
    if (reg_reset_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    dev_idle();
    rd_reg("timing", ADDR_TIMING, TIMING_RESET);
    rd_reg("power", ADDR_PM, PM_RESET);
    av(1'b0, AV_CMD, {16'h0, 1'b0, ADDR_TIMING, 8'h88});
    notes.push_back('{"refused", 32'h200, 32'h200});
    av(1'b1, AV_STAT, 32'h0);
    sreg(1'b1, ADDR_TIMING, 8'hAD);
    rd_reg("timing", ADDR_TIMING, 8'hAD);
    for (int i = 0; i < 8; i++) fmt_case(i[1:0], (i[1] ^ i[0]) & !i[2], i[2], i[2] & i[0]);
    av(1'b0, AV_PINS, 32'h3);
    repeat (10) @(posedge clk_sys);
    chk("pwr_a", PM_SHUTDOWN, pwr_state_a, 32'h3);
    av(1'b0, AV_PINS, 32'h2);
    av(1'b0, AV_PINS, 32'h0);
    dev_idle();
    rd_reg("format", ADDR_FMT, FMT_RESET);
    sreg(1'b1, ADDR_PM, 8'h90);
    av(1'b0, AV_PINS, 32'h1);
    repeat (10) @(posedge clk_sys);
    chk("pwr_a", PM_STANDBY, pwr_state_a, 32'h3);
    chk("pwr_b", PM_SHUTDOWN, pwr_state_b, 32'h3);
    av(1'b0, AV_PINS, 32'h0);
    repeat (400) @(posedge clk_sys);
    chk("pwr_ab", {PM_NORMAL, PM_NORMAL}, {pwr_state_a, pwr_state_b}, 32'hF);
    sreg(1'b1, ADDR_FMT, 8'h04);
    busy_cnt <= 0;
    sreg(1'b1, ADDR_SWRST, SWRST_KEY);
    sreg(1'b1, ADDR_FMT, 8'h07);
    dev_idle();
    chk("busy_len", 32'd640, 32'(busy_cnt), 32'hFFFF_FFFF);
    rd_reg("format", ADDR_FMT, FMT_RESET);
    finish_test();
  end
endmodule : tb_top
